// *** dv/cpcmd_if_properties.sv ***
// cpcmd_if_properties: concurrent checks on the command word interface.
// assumes both ends share CLK_SYS and a synchronous, active-high RST.
`timescale 1ns/1ps
`default_nettype none
module cpcmd_chk
(
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // a write the device must take: flag clear, or a soft reset
    wire logic acc = cmd_wr && (!cmd_rdata[0] || cmd_wdata[15]);

    // reset itself is the cause here, so it cannot also disable the check
    chk_reset_clear: assert property (disable iff (1'b0) RST |=> cmd_rdata == 16'h0000)
        else $error("word not clear after reset");
    chk_write_shows: assert property (acc |=> cmd_rdata == ($past(cmd_wdata) & 16'h8ff1))
        else $error("accepted write not shown");
    chk_host_flag: assert property (cmd_wr |-> cmd_wdata[0])
        else $error("host wrote without pending flag");
    chk_host_waits: assert property (cmd_wr && !cmd_wdata[15] |-> !cmd_rdata[0])
        else $error("host wrote while command pending");
    chk_srst_taken: assert property (cmd_wr && cmd_wdata[15] |=> cmd_rdata == 16'h8001)
        else $error("soft reset write not taken");
    chk_srst_clear: assert property (cmd_rdata[15] && !cmd_wr |=> cmd_rdata == 16'h0000)
        else $error("soft reset word not cleared in two clocks");
    chk_reserved_zero: assert property ((cmd_rdata & 16'h700e) == 16'h0000)
        else $error("reserved bits read nonzero");
    // while a command runs the word either stands or drops only its flag
    chk_flag_only: assert property (cmd_rdata[0] && !cmd_rdata[15] && !cmd_wr |=>
        cmd_rdata == $past(cmd_rdata) || cmd_rdata == ($past(cmd_rdata) & 16'hfffe))
        else $error("word changed beyond the flag");
    chk_done_bound: assert property ($rose(cmd_rdata[0]) && !cmd_rdata[15] |->
        ##[1:120] !cmd_rdata[0])
        else $error("command not completed in time");

    cov_srst_busy: cover property (cmd_wr && cmd_wdata[15] && cmd_rdata[0]);
    cov_hunt_three: cover property (cmd_rdata == 16'h0381 ##[1:20] cmd_rdata == 16'h0380);
    cov_done: cover property ($fell(cmd_rdata[0]) && !$past(cmd_rdata[15]));
endmodule : cpcmd_chk
`default_nettype wire

// *** dv/tb.sv ***
// tb: drives the host end's user side with corner and random commands and checks
// dispatch, halt state and the live word. assumes EXEC_CYC is set small here.
`timescale 1ns/1ps
`default_nettype none
module tb
    import cpcmd_pkg::*;
;
    localparam int EXEC = 4;
    logic            clk, rst, req, srst, ubusy, udone, stb, srst_o, rout, busy_o;
    logic [3:0]      op, ch, bis;
    logic [1:0]      gci;
    logic [NTGT-1:0] tgt, halt, halted;
    logic [NACT-1:0] act;
    logic [CW-1:0]   word;
    logic [31:0]     rng;
    logic            soft_seen;
    int              n_errors, n_tests, cyc, rout_len;

    cpcmd_if bus_if ();
    cpcmd_device #(.EXEC_CYC(EXEC)) cpcmd_device_inst (.CLK_SYS(clk), .RST(rst),
        .BUS(bus_if.dev), .GCI_MODE(gci), .BISYNC_MODE(bis), .CMD_STB(stb),
        .CMD_TGT(tgt), .CMD_ACT(act), .CMD_WORD(word), .SOFT_RST(srst_o),
        .ROUT_BUSY(rout), .TX_HALTED(halt), .CMD_BUSY(busy_o));
    cpcmd_host cpcmd_host_inst (.CLK_SYS(clk), .RST(rst), .BUS(bus_if.hst),
        .USR_REQ(req), .USR_OP(op), .USR_CH(ch), .USR_SRST(srst),
        .USR_BUSY(ubusy), .USR_DONE(udone));
    cpcmd_chk cpcmd_chk_inst (.CLK_SYS(clk), .RST(rst), .cmd_wr(bus_if.cmd_wr),
        .cmd_wdata(bus_if.cmd_wdata), .cmd_rdata(bus_if.cmd_rdata));

    // free-running system clock, 4 ns
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // watchdog, routine length and soft reset pulse, sampled before edge updates
    always @(posedge clk)
    begin
        cyc++;
        if (srst_o === 1'b1)
            soft_seen = 1'b1;
        if (rout === 1'b1)
            rout_len++;
        else if (rout_len != 0)
        begin
            check(rout_len[15:0], RST_ROUT_CYC[15:0], "reset routine length");
            rout_len = 0;
        end
        if (cyc > 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // channel code to one-hot target; shared codes split by opcode
    function automatic logic [NTGT-1:0] exp_tgt(input logic [3:0] o, input logic [3:0] c);
        logic [NTGT-1:0] t;
        t = '0;
        if (c[1:0] == CH_SCC_LO)
            t[c[3:2]] = 1'b1;
        if (c == CH_SPI_TMR)
            t[(o == OP_SET) ? T_TMR : T_SPI] = 1'b1;
        if (c == CH_MC1_DMA1)
            t[(o == OP_GSTOP) ? T_DMA1 : T_MC1] = 1'b1;
        if (c == CH_MC2_DMA2)
            t[(o == OP_GSTOP) ? T_DMA2 : T_MC2] = 1'b1;
        return t;
    endfunction : exp_tgt

    // action per opcode table column; a management channel in GCI mode differs
    function automatic logic [NACT-1:0] exp_act(input logic [3:0] o, input logic [3:0] c);
        logic [NTGT-1:0] t;
        logic [NACT-1:0] a;
        logic            ser, mg, gm, spi;
        t = exp_tgt(o, c);
        a = '0;
        ser = |t[3:0];
        gm = |(gci & t[T_MC2:T_MC1]);
        mg = (|t[T_MC2:T_MC1]) && !gm;
        spi = t[T_SPI];
        case (o)
            OP_INIT_ALL: a = (ser | mg | gm | spi) ? 14'h0003 : '0;
            OP_INIT_RX:  a[A_INIT_RX] = ser | mg | spi;
            OP_INIT_TX:  a[A_INIT_TX] = ser | mg | spi;
            OP_HUNT:     a[A_HUNT] = ser | mg;
            OP_STOP:     a[A_STOP] = ser | mg;
            OP_GSTOP:    a[A_GSTOP] = ser;
            OP_RESTART:  a[A_RESTART] = ser | mg;
            OP_CLOSE_RX: a[A_CLOSE] = ser | mg | spi;
            OP_SET:      a[A_GROUP] = ser;
            OP_GCI_TMO:  a[A_GCI_TMO] = gm;
            OP_ABT_BCS:  a[A_GCI_ABT] = gm;
            default:     a[A_UCODE] = (o[3:2] == OP_UCODE_HI) && (t != '0);
        endcase
        a[A_DMA_INI] = (o == OP_GSTOP) && (|t[T_DMA2:T_DMA1]);
        a[A_TIMER] = (o == OP_SET) && t[T_TMR];
        a[A_BCS] = (o == OP_ABT_BCS) && (|(bis & t[3:0]));
        return a;
    endfunction : exp_act

    // one request on the user side; optionally wait for completion
    task automatic issue(input logic [3:0] o, input logic [3:0] c, input logic s,
                         input logic wt);
        int n;
        @(posedge clk) #1;
        req = 1'b1;
        op = o;
        ch = c;
        srst = s;
        @(posedge clk) #1;
        req = 1'b0;
        @(posedge clk) #1;
        check(bus_if.cmd_rdata, {s, 3'h0, o, c, 4'h1}, "word while running");
        check(16'({busy_o, ubusy}), 16'h0003, "busy flags");
        @(posedge clk) #1;
        check(16'(stb), 16'(!s && !rout), "dispatch strobe");
        n = 1;
        while (wt && udone !== 1'b1 && n < 200)
        begin
            @(posedge clk) #1;
            n++;
        end
        if (wt)
            check(16'(n <= EXEC_MAX_CYC), 16'h0001, "completion latency");
    endtask : issue

    task automatic run(input logic [3:0] o, input logic [3:0] c);
        logic [NTGT-1:0] et;
        logic [NACT-1:0] ea;
        et = exp_tgt(o, c);
        ea = exp_act(o, c);
        issue(o, c, 1'b0, 1'b1);
        if (ea != '0)
        begin
            check(16'(tgt), 16'(et), "target");
            check(16'(act), 16'(ea), "action");
            check(word, {4'h0, o, c, 4'h1}, "dispatched word");
            halted = (ea[A_STOP] | ea[A_GSTOP]) ? (halted | et) : halted;
            halted = ea[A_RESTART] ? (halted & ~et) : halted;
        end
        check(16'(halt), 16'(halted), "transmit halt state");
        check(bus_if.cmd_rdata, {4'h0, o, c, 4'h0}, "word after completion");
        check(16'({busy_o, ubusy}), 16'h0000, "idle flags");
    endtask : run

    // main sequence
    initial
    begin
        {rst, req, srst, soft_seen} = 4'h8;
        {op, ch, bis, gci} = 14'h0000;
        halted = '0;
        rng = 32'h0000_0451;
        {n_errors, n_tests, cyc, rout_len} = {4{32'h0000_0000}};
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check(bus_if.cmd_rdata, 16'h0000, "word after reset");
        run(OP_HUNT, 4'h8);
        $display("test hunt on serial three done");
        for (int c = 0; c < 16; c++)
        begin
            rng = xs(rng);
            gci = rng[1:0];
            bis = rng[5:2];
            for (int o = 0; o < 16; o++)
                run(4'(o), 4'(c));
        end
        $display("test all opcodes and channel codes done");
        repeat (40)
        begin
            rng = xs(rng);
            run(rng[11:8], rng[7:4]);
        end
        $display("test random commands done");
        // soft reset lands while a command is still pending
        issue(OP_HUNT, 4'h0, 1'b0, 1'b0);
        issue(4'h0, 4'h0, 1'b1, 1'b1);
        halted = '0;
        check(16'(soft_seen), 16'h0001, "soft reset pulse");
        check(16'(halt), 16'h0000, "halts cleared by soft reset");
        check(16'(rout), 16'h0001, "reset routine running");
        run(OP_INIT_ALL, 4'h4);
        repeat (70) @(posedge clk);
        $display("test soft reset done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// *** rtl/cpcmd_decode.sv ***
// cpcmd_decode: combinational routing of an opcode and channel code to one
// target and one action, both init actions for code 0; assumes mode inputs are stable while a command runs.
`timescale 1ns/1ps
`default_nettype none
module cpcmd_decode
    import cpcmd_pkg::*;
(
    input  wire logic [OPW-1:0]  op,
    input  wire logic [CHW-1:0]  ch,
    input  wire logic [1:0]      gci_mode,
    input  wire logic [3:0]      bisync_mode,
    output logic      [NTGT-1:0] tgt,
    output logic      [NACT-1:0] act
);
    logic [3:0] scc_hit;
    logic       ch_spi;
    logic       ch_m1;
    logic       ch_m2;
    logic       scc;
    logic       mcu;
    logic       gci;
    logic       spi;
    logic       dma;

    // serial channels sit at channel codes {index, 00}
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_scc
            assign scc_hit[gi] = (ch == {2'(gi), CH_SCC_LO}); // see [R23]
        end
    endgenerate

    // shared codes split by opcode since their command sets never overlap
    assign ch_spi = (ch == CH_SPI_TMR);                         // see [R20]
    assign ch_m1  = (ch == CH_MC1_DMA1);
    assign ch_m2  = (ch == CH_MC2_DMA2);
    assign tgt[3:0]   = scc_hit;
    assign tgt[T_TMR] = ch_spi & (op == OP_SET);
    assign tgt[T_SPI] = ch_spi & (op != OP_SET);
    assign tgt[T_DMA1] = ch_m1 & (op == OP_GSTOP);              // see [R12]
    assign tgt[T_MC1]  = ch_m1 & (op != OP_GSTOP);
    assign tgt[T_DMA2] = ch_m2 & (op == OP_GSTOP);
    assign tgt[T_MC2]  = ch_m2 & (op != OP_GSTOP);

    // target classes, management channels split by their GCI mode
    assign scc = |scc_hit;
    assign gci = (tgt[T_MC1] & gci_mode[0]) | (tgt[T_MC2] & gci_mode[1]);
    assign mcu = (tgt[T_MC1] | tgt[T_MC2]) & ~gci;
    assign spi = tgt[T_SPI];
    assign dma = tgt[T_DMA1] | tgt[T_DMA2];

    // action table; holes in it decode to no action
    assign act[A_INIT_RX] = ((op == OP_INIT_ALL) & (scc | mcu | gci | spi))
                          | ((op == OP_INIT_RX) & (scc | mcu | spi));      // see [R08]
    assign act[A_INIT_TX] = ((op == OP_INIT_ALL) & (scc | mcu | gci | spi))
                          | ((op == OP_INIT_TX) & (scc | mcu | spi));      // see [R08]
    assign act[A_HUNT]    = (op == OP_HUNT) & (scc | mcu);                 // see [R09]
    assign act[A_STOP]    = (op == OP_STOP) & (scc | mcu);                 // see [R10]
    assign act[A_GSTOP]   = (op == OP_GSTOP) & scc;                        // see [R11]
    assign act[A_DMA_INI] = (op == OP_GSTOP) & dma;                        // see [R12]
    assign act[A_RESTART] = (op == OP_RESTART) & (scc | mcu);              // see [R13]
    assign act[A_CLOSE]   = (op == OP_CLOSE_RX) & (scc | mcu | spi);       // see [R14]
    assign act[A_GROUP]   = (op == OP_SET) & scc;                          // see [R15]
    assign act[A_TIMER]   = tgt[T_TMR];                                    // see [R16]
    assign act[A_GCI_TMO] = (op == OP_GCI_TMO) & gci;                      // see [R17]
    assign act[A_GCI_ABT] = (op == OP_ABT_BCS) & gci;                      // see [R17]
    assign act[A_BCS]     = (op == OP_ABT_BCS) & |(scc_hit & bisync_mode); // see [R18]
    assign act[A_UCODE]   = (op[3:2] == OP_UCODE_HI) & |tgt;               // see [R19]
endmodule : cpcmd_decode
`default_nettype wire

// *** rtl/cpcmd_device.sv ***
// cpcmd_device: the communication processor's command word register and the
// sequencer that dispatches each command to its sub-block and then releases
// the pending flag. assumes the host writes through cpcmd_if on CLK_SYS and
// that the sub-blocks act on a one-cycle dispatch strobe.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R01] host sets pending; device clears when done
// [R02] host writes nothing new while pending
// [R03] soft reset accepted regardless of pending
// [R04] soft reset clears word within two clocks
// [R05] host may write during reset routine
// [R06] soft reset spares serial interface, parallel I/O
// [R07] sixteen-bit read-write word, zero after reset
// [R08] codes 0..2 restore both, receive, transmit
// [R09] code 3 restarts frame search
// [R10] code 4 aborts transmit until restart
// [R11] code 5 halts after current frame
// [R12] code 5 on DMA initializes it
// [R13] code 6 resumes from current descriptor
// [R14] code 7 closes receive descriptor early
// [R15] code 8 sets group hash bit
// [R16] code 8 on timers sets one timer
// [R17] GCI codes 9, 10: timeout, abort
// [R18] code 10 resets BISYNC check sequence
// [R19] codes 12..15 reserved for microcode
// [R20] channel field selects shared target
// [R21] only pending flag clears at completion
// [R22] fixed positions of word fields
// [R23] fixed channel code assignments
// [R24] done within 120 clocks, typically 40
module cpcmd_device
    import cpcmd_pkg::*;
#(
    parameter int EXEC_CYC = EXEC_TYP_CYC  // dispatch-to-release time, <= 120
)
(
    input  wire logic            CLK_SYS,
    input  wire logic            RST,
    cpcmd_if.dev                 BUS,
    input  wire logic [1:0]      GCI_MODE,     // management channel in GCI mode
    input  wire logic [3:0]      BISYNC_MODE,  // serial channel in BISYNC mode
    output logic                 CMD_STB,      // one-cycle dispatch strobe
    output logic      [NTGT-1:0] CMD_TGT,      // one-hot target, held
    output logic      [NACT-1:0] CMD_ACT,      // action bits, held; code 0 sets two
    output logic      [CW-1:0]   CMD_WORD,     // word that was dispatched
    output logic                 SOFT_RST,     // channel/processor/timer reset
    output logic                 ROUT_BUSY,    // internal reset routine running
    output logic      [NTGT-1:0] TX_HALTED,    // transmit held by a stop
    output logic                 CMD_BUSY      // pending flag as stored
);
    localparam logic [EXEC_CNT_W-1:0] EXEC_LOAD = EXEC_CNT_W'(EXEC_CYC - 1);
    localparam logic [ROUT_CNT_W-1:0] ROUT_LOAD = ROUT_CNT_W'(RST_ROUT_CYC - 1);

    cpcmd_dev_st_t         st_r;
    cpcmd_dev_st_t         st_nxt;
    logic [CW-1:0]         word_r;
    logic [CW-1:0]         word_nxt;
    logic [EXEC_CNT_W-1:0] cnt_r;
    logic [EXEC_CNT_W-1:0] cnt_nxt;
    logic [ROUT_CNT_W-1:0] rcnt_r;
    logic [ROUT_CNT_W-1:0] rcnt_nxt;
    logic                  rbusy_r;
    logic                  rbusy_nxt;
    logic [NTGT-1:0]       halt_r;
    logic [NTGT-1:0]       halt_nxt;
    logic                  stb_r;
    logic [NTGT-1:0]       tgt_r;
    logic [NACT-1:0]       act_r;
    logic [CW-1:0]         dword_r;
    logic                  srst_r;
    logic [NTGT-1:0]       dec_tgt;
    logic [NACT-1:0]       dec_act;
    logic                  wr_srst;
    logic                  wr_ok;
    logic                  srst_exec;
    logic                  start;
    logic                  finish;
    logic                  stop_any;

    // write acceptance: a write over a pending command is dropped unless it
    // is a soft reset, so a misbehaving host cannot corrupt the one in flight
    assign wr_srst = BUS.cmd_wr & BUS.cmd_wdata[B_SRST];              // see [R03]
    assign wr_ok   = BUS.cmd_wr & (~word_r[B_FLAG] | wr_srst);        // see [R02]

    // a stored soft reset executes in the cycle after it lands
    assign srst_exec = word_r[B_SRST];
    assign start     = (st_r == CPCMD_D_IDLE) & word_r[B_FLAG] & ~srst_exec
                     & ~rbusy_r;                                      // see [R01]
    assign finish    = (st_r == CPCMD_D_RUN) & (cnt_r == '0);         // see [R24]
    assign stop_any  = dec_act[A_STOP] | dec_act[A_GSTOP];

    // field extraction at the fixed positions
    cpcmd_decode u_decode (
        .op          (word_r[B_OP_LO +: OPW]),                        // see [R22]
        .ch          (word_r[B_CH_LO +: CHW]),                        // see [R20]
        .gci_mode    (GCI_MODE),
        .bisync_mode (BISYNC_MODE),
        .tgt         (dec_tgt),
        .act         (dec_act)
    );

    // next register word; a host write outranks the hardware clear so a
    // soft reset landing on the completion cycle is never lost
    always_comb
    begin
        word_nxt = word_r;
        if (wr_ok)
        begin
            word_nxt = BUS.cmd_wdata & CMD_WR_MASK;                   // see [R07]
        end
        else if (srst_exec)
        begin
            word_nxt = CMD_RST_VAL;                                   // see [R04]
        end
        else if (finish)
        begin
            word_nxt = word_r & ~CMD_FLAG_M;                          // see [R21]
        end
    end

    // sequencer: idle until a flagged word is stored, then count out the
    // execution time; a soft reset abandons any command in flight
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        if (srst_exec)
        begin
            st_nxt  = CPCMD_D_IDLE;                                   // see [R03]
            cnt_nxt = '0;
        end
        else if (start)
        begin
            st_nxt  = CPCMD_D_RUN;
            cnt_nxt = EXEC_LOAD;                                      // see [R24]
        end
        else if (st_r == CPCMD_D_RUN)
        begin
            if (finish)
            begin
                st_nxt = CPCMD_D_IDLE;                                // see [R01]
            end
            else
            begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    // reset routine: commands wait it out, but the register stays writable
    // so the host can program parameters straight away
    always_comb
    begin
        rcnt_nxt  = rcnt_r;
        rbusy_nxt = rbusy_r;
        if (srst_exec)
        begin
            rcnt_nxt  = ROUT_LOAD;                                    // see [R05]
            rbusy_nxt = 1'b1;
        end
        else if (rbusy_r)
        begin
            rbusy_nxt = (rcnt_r != '0);
            rcnt_nxt  = (rcnt_r != '0) ? rcnt_r - 1'b1 : rcnt_r;
        end
    end

    // transmit halt tracking: a stop holds the target until a restart or a soft reset;
    // resumption after a graceful halt still needs a ready descriptor
    always_comb
    begin
        halt_nxt = halt_r;
        if (srst_exec)
        begin
            halt_nxt = '0;                                            // see [R06]
        end
        else if (start & stop_any)
        begin
            halt_nxt = halt_r | dec_tgt;                              // see [R10]
        end
        else if (start & dec_act[A_RESTART])
        begin
            halt_nxt = halt_r & ~dec_tgt;                             // see [R13]
        end
    end

    // state registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_r    <= CPCMD_D_IDLE;
            word_r  <= CMD_RST_VAL;                                   // see [R07]
            cnt_r   <= '0;
            rcnt_r  <= '0;
            rbusy_r <= 1'b0;
            halt_r  <= '0;
        end
        else
        begin
            st_r    <= st_nxt;
            word_r  <= word_nxt;
            cnt_r   <= cnt_nxt;
            rcnt_r  <= rcnt_nxt;
            rbusy_r <= rbusy_nxt;
            halt_r  <= halt_nxt;
        end
    end

    // dispatch registers; target and action hold until the next dispatch
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            stb_r   <= 1'b0;
            tgt_r   <= '0;
            act_r   <= '0;
            dword_r <= CMD_RST_VAL;
            srst_r  <= 1'b0;
        end
        else
        begin
            stb_r  <= start;
            srst_r <= srst_exec;                                      // see [R06]
            if (start)
            begin
                tgt_r   <= dec_tgt;
                act_r   <= dec_act;
                dword_r <= word_r;
            end
        end
    end

    // every output is a flop; the read path shows the live word
    assign BUS.cmd_rdata = word_r;
    assign CMD_STB       = stb_r;
    assign CMD_TGT       = tgt_r;
    assign CMD_ACT       = act_r;
    assign CMD_WORD      = dword_r;
    assign SOFT_RST      = srst_r;
    assign ROUT_BUSY     = rbusy_r;
    assign TX_HALTED     = halt_r;
    assign CMD_BUSY      = word_r[B_FLAG];
endmodule : cpcmd_device
`default_nettype wire

// *** rtl/cpcmd_host.sv ***
// cpcmd_host: host side of the command word register. takes a request from
// its user, writes the word with the pending flag and polls until cleared.
// assumes the device end shares CLK_SYS and shows its word live.
`timescale 1ns/1ps
`default_nettype none
module cpcmd_host
    import cpcmd_pkg::*;
(
    input  wire logic           CLK_SYS,
    input  wire logic           RST,
    cpcmd_if.hst                BUS,
    input  wire logic           USR_REQ,   // one-cycle request
    input  wire logic [OPW-1:0] USR_OP,
    input  wire logic [CHW-1:0] USR_CH,
    input  wire logic           USR_SRST,  // request is a soft reset
    output logic                USR_BUSY,  // command outstanding
    output logic                USR_DONE   // one-cycle completion pulse
);
    cpcmd_hst_st_t st_r;
    logic          wr_r;
    logic [CW-1:0] wd_r;
    logic          done_r;
    logic          take;
    logic [CW-1:0] req_word;

    // a normal request is taken only when idle; a soft reset goes at once
    assign take     = USR_REQ & ((st_r == CPCMD_H_IDLE) | USR_SRST);  // see [R02]
    assign req_word = USR_SRST ? (CMD_FLAG_M | CW'(1) << B_SRST)      // see [R03]
                    : (CW'(USR_OP) << B_OP_LO) | (CW'(USR_CH) << B_CH_LO)
                    | CMD_FLAG_M;                                     // see [R01]

    // write, then poll; the write cycle is skipped so a stale flag of zero
    // is never read as completion
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_r   <= CPCMD_H_IDLE;
            wr_r   <= 1'b0;
            wd_r   <= CMD_RST_VAL;
            done_r <= 1'b0;
        end
        else
        begin
            wr_r   <= take;
            done_r <= 1'b0;
            if (take)
            begin
                wd_r <= req_word;                                     // see [R20]
                st_r <= CPCMD_H_WAIT;
            end
            else
            begin
                case (st_r)
                    CPCMD_H_WAIT:
                    begin
                        if (~wr_r & ~BUS.cmd_rdata[B_FLAG])
                        begin
                            st_r   <= CPCMD_H_IDLE;                   // see [R02]
                            done_r <= 1'b1;
                        end
                    end
                    default:
                    begin
                        st_r <= CPCMD_H_IDLE;
                    end
                endcase
            end
        end
    end

    assign BUS.cmd_wr    = wr_r;
    assign BUS.cmd_wdata = wd_r;
    assign USR_BUSY      = (st_r == CPCMD_H_WAIT);
    assign USR_DONE      = done_r;
endmodule : cpcmd_host
`default_nettype wire

// *** rtl/cpcmd_if.sv ***
// cpcmd_if: the host's view of the command word register.
// assumes both ends run on the same system clock; the read value is live.
`timescale 1ns/1ps
`default_nettype none
interface cpcmd_if;
    import cpcmd_pkg::*;
    logic          cmd_wr;     // one-cycle write strobe
    logic [CW-1:0] cmd_wdata;  // word written with the strobe
    logic [CW-1:0] cmd_rdata;  // current register contents

    modport dev (input cmd_wr, input cmd_wdata, output cmd_rdata);
    modport hst (output cmd_wr, output cmd_wdata, input cmd_rdata);
endinterface : cpcmd_if
`default_nettype wire

// *** rtl/cpcmd_pkg.sv ***
// cpcmd_pkg: field layout, codes, reset values and cycle counts of the
// command word register shared by the device end, its decoder and the host end.
// assumes one 250 MHz system clock; every count here is in those clocks.
package cpcmd_pkg;
    // command word layout
    localparam int          CW          = 16;
    localparam int          OPW         = 4;
    localparam int          CHW         = 4;
    localparam int          B_SRST      = 15;
    localparam int          B_OP_LO     = 8;
    localparam int          B_CH_LO     = 4;
    localparam int          B_FLAG      = 0;
    localparam logic [15:0] CMD_RST_VAL = 16'h0000;
    localparam logic [15:0] CMD_WR_MASK = 16'h8ff1; // reserved bits read as zero
    localparam logic [15:0] CMD_FLAG_M  = 16'h0001;

    // operation codes
    localparam logic [3:0] OP_INIT_ALL = 4'h0;
    localparam logic [3:0] OP_INIT_RX  = 4'h1;
    localparam logic [3:0] OP_INIT_TX  = 4'h2;
    localparam logic [3:0] OP_HUNT     = 4'h3;
    localparam logic [3:0] OP_STOP     = 4'h4;
    localparam logic [3:0] OP_GSTOP    = 4'h5;
    localparam logic [3:0] OP_RESTART  = 4'h6;
    localparam logic [3:0] OP_CLOSE_RX = 4'h7;
    localparam logic [3:0] OP_SET      = 4'h8;
    localparam logic [3:0] OP_GCI_TMO  = 4'h9;
    localparam logic [3:0] OP_ABT_BCS  = 4'ha;
    localparam logic [1:0] OP_UCODE_HI = 2'h3;  // codes 1100..1111

    // channel codes
    localparam logic [3:0] CH_SPI_TMR  = 4'h5;
    localparam logic [3:0] CH_MC1_DMA1 = 4'h9;
    localparam logic [3:0] CH_MC2_DMA2 = 4'hd;
    localparam logic [1:0] CH_SCC_LO   = 2'h0;  // serial channels: {index, 00}

    // one-hot target positions
    localparam int NTGT   = 10;
    localparam int T_SCC0 = 0;   // serial channels 1..4 at 0..3
    localparam int T_SPI  = 4;
    localparam int T_TMR  = 5;
    localparam int T_MC1  = 6;
    localparam int T_MC2  = 7;
    localparam int T_DMA1 = 8;
    localparam int T_DMA2 = 9;

    // one-hot action positions
    localparam int NACT      = 14;
    localparam int A_INIT_RX = 0;
    localparam int A_INIT_TX = 1;
    localparam int A_HUNT    = 2;
    localparam int A_STOP    = 3;
    localparam int A_GSTOP   = 4;
    localparam int A_RESTART = 5;
    localparam int A_CLOSE   = 6;
    localparam int A_GROUP   = 7;
    localparam int A_TIMER   = 8;
    localparam int A_DMA_INI = 9;
    localparam int A_GCI_TMO = 10;
    localparam int A_GCI_ABT = 11;
    localparam int A_BCS     = 12;
    localparam int A_UCODE   = 13;

    // timing, in system clocks
    localparam int SRST_CLR_CYC  = 2;
    localparam int RST_ROUT_CYC  = 60;
    localparam int EXEC_TYP_CYC  = 40;
    localparam int EXEC_MAX_CYC  = 120;
    localparam int EXEC_CNT_W    = 7;
    localparam int ROUT_CNT_W    = 6;

    typedef enum logic {CPCMD_D_IDLE, CPCMD_D_RUN} cpcmd_dev_st_t;
    typedef enum logic {CPCMD_H_IDLE, CPCMD_H_WAIT} cpcmd_hst_st_t;
endpackage : cpcmd_pkg
